// [design/uldp_framer.sv]
// Uplink data PDU framer: builds header and payload, emits the block bit-serially.
// Assumes a same-clock bit sink with ready/valid and an AXI4-Lite master.
// Notes on behaviour
// (R1) Header opens with two-bit type field zero.
// (R2) Fill indicator follows type; set when spare capacity remains.
// (R3) Encryption flag covers payload only, never header.
// (R4) Fragment start's encryption flag governs later fragments.
// (R5) Address type: short, event label, migrating, management identity.
// (R6) Address is 10 bits for event label, 24 for identities.
// (R7) Selector: 0 length indication, 1 capacity request, never both.
// (R8) Six-bit length: null, 3..34 octets, two stealing codes, rest reserved.
// (R9) Length counts header plus payload; used when nothing pending.
// (R10) Capacity request: fragment flag, four-bit reservation, zero reserved bit.
// (R11) Full slot with more pending uses capacity request.
// (R12) Header is 37 bits with identity, 23 with event label.
// (R13) Full slot payload limit 231 bits identity, 245 event label.
// (R14) Payload length is total length minus header length.
// (R15) Null PDU ends right after its length field.
// (R16) After a null PDU only fill bits follow.
// (R17) Stealing channel uses first half slot by default.
// (R18) Half slot payload limit 87 bits identity, 101 event label.
// (R19) Code 111111 marks second half stolen for final fragment.
// (R20) Code 111110 marks second half stolen for further or user signalling.
// (R21) Second half carries end-fragment, data or user-signal PDU.
// (R22) Stealing fragments span only the two halves of one slot.
// (R23) Fields in order, MSB first, payload right after header.
// (R24) Receiver discards PDUs with reserved length codes.
//
// The AXI4-Lite register port and the register addresses were left to the implementer.
`timescale 1ns/1ps
module uldp_framer
(
    input  wire logic        SYS_CLK_I,
    input  wire logic        RST_I,
    input  wire logic [7:0]  S_AXI_AWADDR_I,
    input  wire logic        S_AXI_AWVALID_I,
    output logic             S_AXI_AWREADY_O,
    input  wire logic [31:0] S_AXI_WDATA_I,
    input  wire logic [3:0]  S_AXI_WSTRB_I,
    input  wire logic        S_AXI_WVALID_I,
    output logic             S_AXI_WREADY_O,
    output logic [1:0]       S_AXI_BRESP_O,
    output logic             S_AXI_BVALID_O,
    input  wire logic        S_AXI_BREADY_I,
    input  wire logic [7:0]  S_AXI_ARADDR_I,
    input  wire logic        S_AXI_ARVALID_I,
    output logic             S_AXI_ARREADY_O,
    output logic [31:0]      S_AXI_RDATA_O,
    output logic [1:0]       S_AXI_RRESP_O,
    output logic             S_AXI_RVALID_O,
    input  wire logic        S_AXI_RREADY_I,
    output logic             TX_BIT_O,
    output logic             TX_VALID_O,
    output logic             TX_LAST_O,
    input  wire logic        TX_READY_I
);
    // Byte-lane merge for register writes
    function automatic logic [31:0] merge_bytes(input logic [31:0] old_v,
                                                input logic [31:0] new_v,
                                                input logic [3:0]  strb);
        logic [31:0] res = old_v;
        for (int b = 0; b < 4; b++)
        begin
            if (strb[b])
            begin
                res[b*8 +: 8] = new_v[b*8 +: 8];
            end
        end
        return res;
    endfunction : merge_bytes
    // Bus slave state
    logic              aw_hold_r;
    logic [5:0]        aw_idx_r;
    logic              w_hold_r;
    logic [31:0]       w_data_r;
    logic [3:0]        w_strb_r;
    logic              bvalid_r;
    logic [1:0]        bresp_r;
    logic              rvalid_r;
    logic [31:0]       rdata_r;
    logic [1:0]        rresp_r;
    // Software-visible state
    uldp_pkg::uldp_cfg_s cfg_r;
    logic [23:0]       addr_r;
    logic [8:0]        plen_r;
    logic [31:0]       pay_r [uldp_pkg::PAY_WORDS];
    logic              lock_r;
    logic              lock_enc_r;
    logic              err_r;
    logic [5:0]        code_r;
    // Frame engine state
    uldp_pkg::uldp_state_e state_r;
    logic [uldp_pkg::HDR_W-1:0] hdr_r;
    logic [5:0]        hdr_len_r;
    logic [8:0]        tot_r;
    logic [8:0]        cap_r;
    logic [8:0]        pos_r;
    logic              tx_bit_r;
    logic              tx_valid_r;
    logic              tx_last_r;
    // Write path decode
    wire logic        busy_w     = (state_r != uldp_pkg::ST_IDLE);
    wire logic        do_wr_w    = aw_hold_r && w_hold_r && !bvalid_r;
    wire logic        wr_ctrl_w  = do_wr_w && (aw_idx_r == uldp_pkg::IDX_CTRL);
    wire logic        wr_cfg_w   = do_wr_w && (aw_idx_r == uldp_pkg::IDX_HDR_CFG) && !busy_w;
    wire logic        wr_addr_w  = do_wr_w && (aw_idx_r == uldp_pkg::IDX_ADDRESS) && !busy_w;
    wire logic        wr_plen_w  = do_wr_w && (aw_idx_r == uldp_pkg::IDX_PAY_LEN) && !busy_w;
    wire logic        wr_pay_w   = do_wr_w && (aw_idx_r[5:3] == uldp_pkg::IDX_PAY_BASE[5:3]) &&
                                   !busy_w;
    wire logic        wr_known_w = (aw_idx_r == uldp_pkg::IDX_CTRL) || wr_cfg_w || wr_addr_w ||
                                   (aw_idx_r == uldp_pkg::IDX_STATUS) || wr_plen_w || wr_pay_w;
    wire logic        start_req_w = wr_ctrl_w && w_strb_r[0] && w_data_r[uldp_pkg::CTRL_START] &&
                                    !busy_w;
    wire logic        clr_lock_w  = wr_ctrl_w && w_strb_r[0] && w_data_r[uldp_pkg::CTRL_CLR_LOCK];
    wire logic        clr_err_w   = wr_ctrl_w && w_strb_r[0] && w_data_r[uldp_pkg::CTRL_CLR_ERR];
    // Header fields from the current configuration
    wire logic        is_event_w = (cfg_r.addr_type == uldp_pkg::AT_EVENT_LABEL); // see (R5)
    wire logic [5:0]  hdr_len_w  = is_event_w ? uldp_pkg::HDR_LEN_EVENT :
                                                uldp_pkg::HDR_LEN_ID;  // see (R12)
    wire logic [8:0]  max_pay_w  = cfg_r.steal ? (is_event_w ? uldp_pkg::PAY_HALF_EVENT :
                                                 uldp_pkg::PAY_HALF_ID) :   // see (R18)
                                   (is_event_w ? uldp_pkg::PAY_FULL_EVENT :
                                                 uldp_pkg::PAY_FULL_ID);    // see (R13)
    // Block capacity: the first half slot when stealing, otherwise the full slot
    wire logic [8:0]  cap_w      = {3'h0, hdr_len_w} + max_pay_w;          // see (R17)
    wire logic [8:0]  pay_len_w  = cfg_r.null_pdu ? 9'h000 : plen_r;       // see (R15)
    wire logic [8:0]  tot_w      = {3'h0, hdr_len_w} + pay_len_w;          // see (R14)
    wire logic [9:0]  oct_sum_w  = {1'h0, tot_w} + 10'h007;
    wire logic [5:0]  octets_w   = oct_sum_w[8:3];                         // see (R9)
    wire logic        too_long_w = !cfg_r.null_pdu && (plen_r > max_pay_w);
    // Capacity request only on the full slot with more pending
    wire logic        use_cap_w  = !cfg_r.null_pdu && !cfg_r.steal && cfg_r.more; // see (R11)
    // A stealing fragment must close in the second half of the same slot
    wire logic        steal_fin_w = cfg_r.half_use == uldp_pkg::HALF_FINAL ||
                                    cfg_r.frag_start;                      // see (R22)
    wire logic        steal_sel_w = !cfg_r.null_pdu && cfg_r.steal && // see (R21)
                                    (steal_fin_w || cfg_r.half_use != uldp_pkg::HALF_NONE);
    wire logic [5:0]  steal_code_w = steal_fin_w ? uldp_pkg::LEN_STEAL_FINAL :   // see (R19)
                                                   uldp_pkg::LEN_STEAL_FURTHER;  // see (R20)
    wire logic [5:0]  len_code_w = cfg_r.null_pdu ? uldp_pkg::LEN_NULL :
                                   steal_sel_w    ? steal_code_w : octets_w;     // see (R8)
    wire logic [5:0]  cap_req_w  = {cfg_r.frag_start, cfg_r.resv_req,
                                    uldp_pkg::RESERVED_BIT};               // see (R10)
    wire logic        sel_w      = use_cap_w ? uldp_pkg::SEL_CAPACITY :
                                               uldp_pkg::SEL_LENGTH;       // see (R7)
    wire logic [5:0]  tail_w     = use_cap_w ? cap_req_w : len_code_w;
    wire logic        fill_ind_w = (tot_w < cap_w);                        // see (R2)
    // Lock overrides software while a fragmented payload is open
    wire logic        enc_used_w = lock_r ? lock_enc_r : cfg_r.enc;        // see (R4)
    wire logic [uldp_pkg::HDR_W-1:0] hdr_id_w =
        {uldp_pkg::PDU_TYPE_DATA, fill_ind_w, enc_used_w, cfg_r.addr_type,
         addr_r, sel_w, tail_w};                                           // see (R1) (R3) (R6)
    wire logic [uldp_pkg::HDR_W-1:0] hdr_ev_w =
        {14'h0000, uldp_pkg::PDU_TYPE_DATA, fill_ind_w, enc_used_w, cfg_r.addr_type,
         addr_r[9:0], sel_w, tail_w};                                      // see (R6)
    wire logic        launch_w   = start_req_w && !too_long_w;
    // Lock taken on any launched fragment start that is not a null PDU
    wire logic        frag_go_w  = launch_w && cfg_r.frag_start && !cfg_r.null_pdu;
    // Bit selection at the current position
    wire logic [8:0]  hidx_w     = {3'h0, hdr_len_r} - pos_r - 9'h001;
    wire logic [8:0]  pidx_w     = pos_r - {3'h0, hdr_len_r};
    wire logic [31:0] pword_w    = pay_r[pidx_w[7:5]];
    wire logic        in_hdr_w   = pos_r < {3'h0, hdr_len_r};
    wire logic        in_pay_w   = pos_r < tot_r;
    // Fill pattern is a one then zeros, so a receiver can find the payload end
    wire logic        fill_bit_w = (pos_r == tot_r) ? uldp_pkg::FILL_FIRST_BIT : 1'h0; // see (R16)
    wire logic        next_bit_w = in_hdr_w ? hdr_r[hidx_w[5:0]] :
                                   in_pay_w ? pword_w[~pidx_w[4:0]] : fill_bit_w; // see (R23)
    wire logic        adv_w      = (state_r == uldp_pkg::ST_RUN) && (!tx_valid_r || TX_READY_I);
    wire logic        last_pos_w = (pos_r == cap_r - 9'h001);
    // Read path decode
    wire logic [5:0]  ar_idx_w   = S_AXI_ARADDR_I[7:2];
    wire logic [31:0] status_w   = {18'h00000, code_r, 4'h0, lock_enc_r, lock_r, err_r, busy_w};
    wire logic        rd_pay_w   = (ar_idx_w[5:3] == uldp_pkg::IDX_PAY_BASE[5:3]);
    wire logic        rd_known_w = rd_pay_w || (ar_idx_w <= uldp_pkg::IDX_STATUS);
    wire logic [31:0] rd_mux_w   = (ar_idx_w == uldp_pkg::IDX_HDR_CFG) ? {19'h00000, cfg_r} :
        (ar_idx_w == uldp_pkg::IDX_ADDRESS) ? {8'h00, addr_r} :
        (ar_idx_w == uldp_pkg::IDX_PAY_LEN) ? {23'h000000, plen_r} :
        (ar_idx_w == uldp_pkg::IDX_STATUS)  ? status_w :
        rd_pay_w                            ? pay_r[ar_idx_w[2:0]] : 32'h00000000;
    // Handshake outputs
    assign S_AXI_AWREADY_O = !aw_hold_r && !bvalid_r;
    assign S_AXI_WREADY_O  = !w_hold_r && !bvalid_r;
    assign S_AXI_BVALID_O  = bvalid_r;
    assign S_AXI_BRESP_O   = bresp_r;
    assign S_AXI_ARREADY_O = !rvalid_r;
    assign S_AXI_RVALID_O  = rvalid_r;
    assign S_AXI_RDATA_O   = rdata_r;
    assign S_AXI_RRESP_O   = rresp_r;
    assign TX_BIT_O        = tx_bit_r;
    assign TX_VALID_O      = tx_valid_r;
    assign TX_LAST_O       = tx_last_r;
    // Address and data captured in either order
    always_ff @(posedge SYS_CLK_I or posedge RST_I)
    begin
        if (RST_I)
        begin
            aw_hold_r <= 1'h0;
            aw_idx_r  <= 6'h00;
            w_hold_r  <= 1'h0;
            w_data_r  <= 32'h00000000;
            w_strb_r  <= 4'h0;
        end
        else
        begin
            if (S_AXI_AWVALID_I && S_AXI_AWREADY_O)
            begin
                aw_hold_r <= 1'h1;
                aw_idx_r  <= S_AXI_AWADDR_I[7:2];
            end
            else if (do_wr_w)
            begin
                aw_hold_r <= 1'h0;
            end
            if (S_AXI_WVALID_I && S_AXI_WREADY_O)
            begin
                w_hold_r <= 1'h1;
                w_data_r <= S_AXI_WDATA_I;
                w_strb_r <= S_AXI_WSTRB_I;
            end
            else if (do_wr_w)
            begin
                w_hold_r <= 1'h0;
            end
        end
    end
    // Write response; unmapped or busy-locked registers give SLVERR
    always_ff @(posedge SYS_CLK_I or posedge RST_I)
    begin
        if (RST_I)
        begin
            bvalid_r <= 1'h0;
            bresp_r  <= uldp_pkg::RESP_OKAY;
        end
        else if (do_wr_w)
        begin
            bvalid_r <= 1'h1;
            bresp_r  <= wr_known_w ? uldp_pkg::RESP_OKAY : uldp_pkg::RESP_SLVERR;
        end
        else if (S_AXI_BREADY_I)
        begin
            bvalid_r <= 1'h0;
        end
    end
    // Read channel, one cycle from address to data
    always_ff @(posedge SYS_CLK_I or posedge RST_I)
    begin
        if (RST_I)
        begin
            rvalid_r <= 1'h0;
            rdata_r  <= 32'h00000000;
            rresp_r  <= uldp_pkg::RESP_OKAY;
        end
        else if (S_AXI_ARVALID_I && !rvalid_r)
        begin
            rvalid_r <= 1'h1;
            rdata_r  <= rd_mux_w;
            rresp_r  <= rd_known_w ? uldp_pkg::RESP_OKAY : uldp_pkg::RESP_SLVERR;
        end
        else if (S_AXI_RREADY_I)
        begin
            rvalid_r <= 1'h0;
        end
    end
    // Configuration and payload; frozen while a block is sent
    always_ff @(posedge SYS_CLK_I or posedge RST_I)
    begin
        if (RST_I)
        begin
            cfg_r  <= uldp_pkg::HDR_CFG_RESET;
            addr_r <= 24'h000000;
            plen_r <= 9'h000;
            for (int i = 0; i < uldp_pkg::PAY_WORDS; i++)
            begin
                pay_r[i] <= 32'h00000000;
            end
        end
        else
        begin
            if (wr_cfg_w)
            begin
                cfg_r <= 13'(merge_bytes({19'h00000, cfg_r}, w_data_r, w_strb_r));
            end
            if (wr_addr_w)
            begin
                addr_r <= 24'(merge_bytes({8'h00, addr_r}, w_data_r, w_strb_r));
            end
            if (wr_plen_w)
            begin
                plen_r <= 9'(merge_bytes({23'h000000, plen_r}, w_data_r, w_strb_r));
            end
            if (wr_pay_w)
            begin
                pay_r[aw_idx_r[2:0]] <= merge_bytes(pay_r[aw_idx_r[2:0]], w_data_r, w_strb_r);
            end
        end
    end
    // Lock and error flags; a set beats a same-cycle clear
    always_ff @(posedge SYS_CLK_I or posedge RST_I)
    begin
        if (RST_I)
        begin
            lock_r     <= 1'h0;
            lock_enc_r <= 1'h0;
            err_r      <= 1'h0;
        end
        else
        begin
            if (frag_go_w)
            begin
                lock_r     <= 1'h1;         // see (R4)
                lock_enc_r <= enc_used_w;
            end
            else if (clr_lock_w)
            begin
                lock_r <= 1'h0;
            end
            if (start_req_w && too_long_w)
            begin
                err_r <= 1'h1;              // see (R13) (R18)
            end
            else if (clr_err_w)
            begin
                err_r <= 1'h0;
            end
        end
    end
    // Frame engine: latch header at start, then one bit per accepted beat
    always_ff @(posedge SYS_CLK_I or posedge RST_I)
    begin
        if (RST_I)
        begin
            state_r   <= uldp_pkg::ST_IDLE;
            hdr_r     <= '0;
            hdr_len_r <= 6'h00;
            tot_r     <= 9'h000;
            cap_r     <= 9'h000;
            pos_r     <= 9'h000;
            code_r    <= 6'h00;
        end
        else
        begin
            unique case (state_r)
                uldp_pkg::ST_IDLE:
                begin
                    if (launch_w)
                    begin
                        hdr_r     <= is_event_w ? hdr_ev_w : hdr_id_w;
                        hdr_len_r <= hdr_len_w;
                        tot_r     <= tot_w;
                        cap_r     <= cap_w;
                        pos_r     <= 9'h000;
                        code_r    <= tail_w;
                        state_r   <= uldp_pkg::ST_RUN;
                    end
                end
                uldp_pkg::ST_RUN:
                begin
                    if (adv_w)
                    begin
                        pos_r <= pos_r + 9'h001;
                        if (last_pos_w)
                        begin
                            state_r <= uldp_pkg::ST_DRAIN;
                        end
                    end
                end
                uldp_pkg::ST_DRAIN:
                begin
                    if (TX_READY_I)
                    begin
                        state_r <= uldp_pkg::ST_IDLE;
                    end
                end
            endcase
        end
    end
    // Output bit; holds until the sink takes it
    always_ff @(posedge SYS_CLK_I or posedge RST_I)
    begin
        if (RST_I)
        begin
            tx_bit_r   <= 1'h0;
            tx_valid_r <= 1'h0;
            tx_last_r  <= 1'h0;
        end
        else if (adv_w)
        begin
            tx_bit_r   <= next_bit_w;       // see (R23)
            tx_valid_r <= 1'h1;
            tx_last_r  <= last_pos_w;
        end
        else if (TX_READY_I)
        begin
            tx_valid_r <= 1'h0;
            tx_last_r  <= 1'h0;
        end
    end
endmodule : uldp_framer

// [design/uldp_pkg.sv]
// Constants, field layouts and carrier types for the uplink data PDU framer.
// Assumes one clock domain and 32-bit AXI4-Lite register access.
package uldp_pkg;

    // PDU field codes
    localparam logic [1:0] PDU_TYPE_DATA     = 2'h0;
    localparam logic [1:0] AT_SHORT_ID       = 2'h0;
    localparam logic [1:0] AT_EVENT_LABEL    = 2'h1;
    localparam logic [1:0] AT_MIGRATING_ID   = 2'h2;
    localparam logic [1:0] AT_MANAGEMENT_ID  = 2'h3;
    localparam logic       SEL_LENGTH        = 1'h0;
    localparam logic       SEL_CAPACITY      = 1'h1;
    localparam logic       RESERVED_BIT      = 1'h0;
    localparam logic       FILL_FIRST_BIT    = 1'h1;

    // Length codes
    localparam logic [5:0] LEN_NULL          = 6'h00;
    localparam logic [5:0] LEN_MIN_OCTETS    = 6'h03;
    localparam logic [5:0] LEN_MAX_OCTETS    = 6'h22;
    localparam logic [5:0] LEN_STEAL_FURTHER = 6'h3E;
    localparam logic [5:0] LEN_STEAL_FINAL   = 6'h3F;

    // Header and payload sizes in bits; payload buffer size in 32-bit words
    localparam logic [5:0] HDR_LEN_ID        = 6'h25;
    localparam logic [5:0] HDR_LEN_EVENT     = 6'h17;
    localparam logic [8:0] PAY_FULL_ID       = 9'h0E7;
    localparam logic [8:0] PAY_FULL_EVENT    = 9'h0F5;
    localparam logic [8:0] PAY_HALF_ID       = 9'h057;
    localparam logic [8:0] PAY_HALF_EVENT    = 9'h065;
    localparam int         HDR_W             = 37;
    localparam int         PAY_WORDS         = 8;

    // Second-half usage codes
    localparam logic [1:0] HALF_NONE         = 2'h0;
    localparam logic [1:0] HALF_FINAL        = 2'h1;
    localparam logic [1:0] HALF_FURTHER      = 2'h2;
    localparam logic [1:0] HALF_USER         = 2'h3;

    // Register word indices (byte address = index * 4)
    localparam logic [5:0] IDX_CTRL          = 6'h00;
    localparam logic [5:0] IDX_HDR_CFG       = 6'h01;
    localparam logic [5:0] IDX_ADDRESS       = 6'h02;
    localparam logic [5:0] IDX_PAY_LEN       = 6'h03;
    localparam logic [5:0] IDX_STATUS        = 6'h04;
    localparam logic [5:0] IDX_PAY_BASE      = 6'h08;

    // Control bits
    localparam int CTRL_START     = 0;
    localparam int CTRL_CLR_LOCK  = 1;
    localparam int CTRL_CLR_ERR   = 2;
    // Status bit positions
    localparam int ST_BUSY        = 0;
    localparam int ST_ERR         = 1;
    localparam int ST_LOCK        = 2;
    localparam int ST_LOCK_ENC    = 3;
    localparam int ST_CODE_LSB    = 8;

    localparam logic [1:0] RESP_OKAY   = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;
    localparam logic [12:0] HDR_CFG_RESET = 13'h0000;

    // Header configuration register, low 13 bits
    typedef struct packed {
        logic [3:0] resv_req;
        logic       frag_start;
        logic [1:0] half_use;
        logic       steal;
        logic       null_pdu;
        logic       more;
        logic       enc;
        logic [1:0] addr_type;
    } uldp_cfg_s;

    typedef enum logic [1:0] {
        ST_IDLE,
        ST_RUN,
        ST_DRAIN
    } uldp_state_e;

endpackage : uldp_pkg

// [sim/uldp_framer_assertions.sv]
// Port-level checker for the framer, bound to its top module.
// Assumes one clock domain and the active-high reset.
`timescale 1ns/1ps
module uldp_framer_assertions
(
    input wire logic        SYS_CLK_I, RST_I, S_AXI_BVALID_O, S_AXI_BREADY_I,
    input wire logic [1:0]  S_AXI_BRESP_O,
    input wire logic        S_AXI_RVALID_O, S_AXI_RREADY_I, S_AXI_ARREADY_O,
    input wire logic [31:0] S_AXI_RDATA_O,
    input wire logic        S_AXI_AWREADY_O, S_AXI_WREADY_O,
    input wire logic        TX_BIT_O, TX_VALID_O, TX_LAST_O, TX_READY_I
);
    logic [8:0] bits_r;
    wire        take = TX_VALID_O && TX_READY_I;
    // Bits taken so far in the current block
    always_ff @(posedge SYS_CLK_I or posedge RST_I)
        if (RST_I) bits_r <= 9'h000;
        else if (take) bits_r <= TX_LAST_O ? 9'h000 : bits_r + 9'h001;
    default clocking cb @(posedge SYS_CLK_I); endclocking
    default disable iff (RST_I);
    sequence s_last; take && TX_LAST_O; endsequence
    sequence s_idle; !TX_VALID_O; endsequence
    property p_b_hold; S_AXI_BVALID_O && !S_AXI_BREADY_I |=> S_AXI_BVALID_O && $stable(S_AXI_BRESP_O); endproperty
    a_b_hold: assert property (p_b_hold) else $error("write response dropped");
    property p_r_hold; S_AXI_RVALID_O && !S_AXI_RREADY_I |=> S_AXI_RVALID_O && $stable(S_AXI_RDATA_O); endproperty
    a_r_hold: assert property (p_r_hold) else $error("read data dropped");
    property p_aw_block; S_AXI_BVALID_O |-> !S_AXI_AWREADY_O && !S_AXI_WREADY_O; endproperty
    a_aw_block: assert property (p_aw_block) else $error("write taken in response");
    property p_ar_block; S_AXI_RVALID_O |-> !S_AXI_ARREADY_O; endproperty
    a_ar_block: assert property (p_ar_block) else $error("read taken in response");
    property p_tx_hold; TX_VALID_O && !TX_READY_I |=> TX_VALID_O && $stable(TX_BIT_O) && $stable(TX_LAST_O); endproperty
    a_tx_hold: assert property (p_tx_hold) else $error("bit changed in stall");
    property p_last_end; s_last |=> s_idle; endproperty
    a_last_end: assert property (p_last_end) else $error("bits after block end");
    property p_frame_len; s_last |-> bits_r == 9'h10B || bits_r == 9'h07B; endproperty
    a_frame_len: assert property (p_frame_len) else $error("block size wrong");
    property p_type_zero; take && bits_r < 9'h002 |-> !TX_BIT_O; endproperty
    a_type_zero: assert property (p_type_zero) else $error("type field not zero");
endmodule : uldp_framer_assertions
bind uldp_framer uldp_framer_assertions i_uldp_framer_assertions (.*);

// [sim/uldp_framer_tb.sv]
// Self-checking bench: registers over AXI4-Lite, blocks captured by the sink.
// Assumes the framer, its checker and the sink model are compiled first.
`timescale 1ns/1ps
module uldp_framer_tb;
    localparam logic [31:0] pay_w = 32'hC3A596F0;
    logic clk = 1'b0, rst = 1'b1, awv = 1'b0, wv = 1'b0, br = 1'b0;
    logic arv = 1'b0, rr = 1'b0, slow = 1'b0, clr = 1'b0;
    logic [7:0] awa = 8'h00, ara = 8'h00;
    logic [31:0] wd = 32'h0, rdat, d;
    logic [1:0] brs, rrs, r;
    logic awr, wr_r, arr, bv, rv, txb, txv, txl, txr;
    logic [267:0] rx, e;
    logic [8:0] lpos;
    logic [2:0] h;
    int fails = 0, total_checks = 0, n;
    uldp_framer i_uldp_framer (.SYS_CLK_I(clk), .RST_I(rst), .S_AXI_AWADDR_I(awa),
        .S_AXI_AWVALID_I(awv), .S_AXI_AWREADY_O(awr), .S_AXI_WDATA_I(wd),
        .S_AXI_WSTRB_I(4'hF), .S_AXI_WVALID_I(wv), .S_AXI_WREADY_O(wr_r),
        .S_AXI_BRESP_O(brs), .S_AXI_BVALID_O(bv), .S_AXI_BREADY_I(br),
        .S_AXI_ARADDR_I(ara), .S_AXI_ARVALID_I(arv), .S_AXI_ARREADY_O(arr),
        .S_AXI_RDATA_O(rdat), .S_AXI_RRESP_O(rrs), .S_AXI_RVALID_O(rv),
        .S_AXI_RREADY_I(rr), .TX_BIT_O(txb), .TX_VALID_O(txv), .TX_LAST_O(txl),
        .TX_READY_I(txr));
    uldp_sink i_uldp_sink (.clk_i(clk), .rst_i(rst), .clr_i(clr), .slow_i(slow),
        .bit_i(txb), .valid_i(txv), .last_i(txl), .ready_o(txr), .rx_o(rx),
        .pos_o(), .lpos_o(lpos));
    initial forever #20 clk = ~clk;
    task check(input string nm, input logic [267:0] s, input logic [267:0] x);
        total_checks++;
        if (s !== x) begin fails++; $display("[ERR] %s expected %h seen %h", nm, x, s); end
    endtask : check
    task test_done();
        $display("checks %0d mismatches %0d", total_checks, fails);
        if (fails == 0 && total_checks > 0) $display("SIMULATION PASSED");
        else $display("SIMULATION FAILED");
        $finish;
    endtask : test_done
    // Address and data offered together, each released once taken
    task wrw(input logic [7:0] a, input logic [31:0] v);
        @(posedge clk);
        awa <= a; wd <= v; awv <= 1'b1; wv <= 1'b1; br <= 1'b1;
        do begin @(negedge clk); h = {awr, wr_r, bv}; r = brs; @(posedge clk);
            if (h[2]) awv <= 1'b0; if (h[1]) wv <= 1'b0; end while (!h[0]);
        br <= 1'b0;
    endtask : wrw
    task rdw(input logic [7:0] a);
        @(posedge clk);
        ara <= a; arv <= 1'b1; rr <= 1'b1;
        do begin @(negedge clk); h = {arr, rv, rv}; d = rdat; r = rrs; @(posedge clk);
            if (h[2]) arv <= 1'b0; end while (!h[0]);
        rr <= 1'b0;
    endtask : rdw
    task push(input logic [23:0] v, input int w);
        for (int i = w - 1; i >= 0; i--) begin e[267 - n] = v[i]; n++; end
    endtask : push
    // Configure, start, rebuild the expected block
    task run(input logic [12:0] cfg, input logic [8:0] pl, input logic encx,
             input logic [6:0] tail, input logic [8:0] cap);
        wrw(8'h04, {19'h0, cfg});
        wrw(8'h0C, {23'h0, pl});
        @(posedge clk) clr <= 1'b1;
        @(posedge clk) clr <= 1'b0;
        wrw(8'h00, 32'h1);
        for (int i = 0; i < 2000 && lpos == 9'h000; i++) @(posedge clk);
        e = '0; n = 0;
        push(24'h0, 2); push(24'h1, 1); push({23'h0, encx}, 1);
        push({22'h0, cfg[1:0]}, 2); push(24'hABCDEF, cfg[1:0] == 2'h1 ? 10 : 24);
        push({17'h0, tail}, 7);
        if (!cfg[4]) for (int i = 0; i < pl; i++) push({23'h0, pay_w[31 - i]}, 1);
        e[267 - n] = 1'b1;
        check("frame", rx, e);
        check("last", 268'(lpos), 268'(cap));
    endtask : run
    initial begin
        repeat (20) @(posedge clk);
        rst <= 1'b0;
        wrw(8'h08, 32'h00ABCDEF);
        wrw(8'h20, pay_w);
        slow <= 1'b1;
        run(13'h0001, 9'h014, 1'b0, 7'h06, 9'h10C);
        slow <= 1'b0;
        run(13'h130C, 9'h020, 1'b1, 7'h72, 9'h10C);
        rdw(8'h10);
        check("lock", 268'(d[3:2]), 268'h3);
        run(13'h0013, 9'h020, 1'b1, 7'h00, 9'h10C);
        wrw(8'h00, 32'h2);
        run(13'h0062, 9'h010, 1'b0, 7'h3F, 9'h07C);
        run(13'h00A1, 9'h008, 1'b0, 7'h3E, 9'h07C);
        wrw(8'h04, 32'h0); wrw(8'h0C, 32'hE8); wrw(8'h00, 32'h1);
        check("bresp", 268'(r), 268'h0);
        rdw(8'h10);
        check("error", 268'(d[1:0]), 268'h2);
        rdw(8'h14);
        check("unmapped", 268'(r), 268'h2);
        test_done();
    end
    // Whole run needs under two thousand cycles
    initial begin repeat (10000) @(posedge clk); fails++; test_done(); end
endmodule : uldp_framer_tb

// [sim/uldp_sink.sv]
// Bit sink model standing in for the base station receiver.
// Assumes the same clock as the framer; a clear pulse precedes each block.
`timescale 1ns/1ps
module uldp_sink
(
    input  wire logic         clk_i,
    input  wire logic         rst_i,
    input  wire logic         clr_i,
    input  wire logic         slow_i,
    input  wire logic         bit_i,
    input  wire logic         valid_i,
    input  wire logic         last_i,
    output logic              ready_o,
    output logic [267:0]      rx_o,
    output logic [8:0]        pos_o,
    output logic [8:0]        lpos_o
);
    // Capture bits first-in at the top; slow mode stalls every other cycle
    always_ff @(posedge clk_i or posedge rst_i)
    begin
        if (rst_i)
        begin
            ready_o <= 1'b0;
            rx_o <= '0;
            pos_o <= 9'h000;
            lpos_o <= 9'h000;
        end
        else if (clr_i)
        begin
            rx_o <= '0;
            pos_o <= 9'h000;
            lpos_o <= 9'h000;
        end
        else
        begin
            ready_o <= slow_i ? ~ready_o : 1'b1;
            if (valid_i && ready_o)
            begin
                rx_o[267 - pos_o] <= bit_i;
                pos_o <= pos_o + 9'h001;
                if (last_i)
                    lpos_o <= pos_o + 9'h001;
            end
        end
    end
endmodule : uldp_sink
